//--- cct_defs.svh
// Register indices, field positions, reset values and prescaler widths for the compare timer
`ifndef CCT_DEFS_SVH
`define CCT_DEFS_SVH
`define CCT_IDX_CTRL    16'hFFB6
`define CCT_IDX_STAT    16'hFFB7
`define CCT_IDX_CNT_H   16'hFFB8
`define CCT_IDX_CNT_L   16'hFFB9
`define CCT_IDX_CMP_H   16'hFFBA
`define CCT_IDX_CMP_L   16'hFFBB
`define CCT_IDX_AUX     16'hFFBC
`define CCT_CTRL_RST    8'h00
`define CCT_STAT_RST    8'h00
`define CCT_AUX_RST     5'h00
`define CCT_CNT_RST     8'h00
`define CCT_CMP_RST     8'hFF
`define CCT_BYTE_MAX    8'hFF
`define CCT_WIDE_MAX    16'hFFFF
`define CCT_WIDE_ZERO   16'h0000
`define CCT_BIT_OVF_H   7
`define CCT_BIT_CMF_H   6
`define CCT_BIT_OVF_L   3
`define CCT_BIT_CMF_L   2
`define CCT_BIT_OL_H    7
`define CCT_BIT_OL_L    3
`define CCT_BIT_REQ_L   3
`define CCT_BIT_REQ_H   4
`define CCT_BIT_OVIE_H  5
`define CCT_BIT_CCLR_H  4
`define CCT_BIT_OVIE_L  1
`define CCT_BIT_CCLR_L  0
`define CCT_BIT_IEN_H   2
`define CCT_BIT_IEN_L   1
`define CCT_BIT_EDGE    0
`define CCT_DIV32_BITS  5
`define CCT_DIV16_BITS  4
`define CCT_DIV4_BITS   2
`define CCT_DIV2_BITS   1
`endif

//--- cct_far_side.sv
// Far-side model: event source on the input pin and edge counters on both toggle pins
`timescale 1ns/10ps
`default_nettype none
module cct_far_side (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        tog_h_i,
    input  wire logic        tog_l_i,
    output logic             event_o,
    output logic      [15:0] edges_h_o,
    output logic      [15:0] edges_l_o
);
    logic tog_h_r;
    logic tog_l_r;

    initial event_o = 1'b0;

    // Each pulse ends in one falling edge; w sets prompt or slow pacing
    task automatic pulse(input int n, input int w);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            event_o <= 1'b1;
            repeat (w) @(posedge clk_i);
            event_o <= 1'b0;
            repeat (w) @(posedge clk_i);
        end
    endtask

    always_ff @(posedge clk_i) begin
        tog_h_r <= tog_h_i;
        tog_l_r <= tog_l_i;
        if (rst_i) begin
            edges_h_o <= 16'h0000;
            edges_l_o <= 16'h0000;
        end else begin
            edges_h_o <= edges_h_o + {15'h0000, tog_h_i ^ tog_h_r};
            edges_l_o <= edges_l_o + {15'h0000, tog_l_i ^ tog_l_r};
        end
    end
endmodule // cct_far_side
`default_nettype wire

//--- cct_pkg.sv
// Packed field layouts shared by the compare timer files
package cct_pkg;
    typedef struct packed {
        logic       out_level_high;
        logic [2:0] clk_sel_high;
        logic       out_level_low;
        logic [2:0] clk_sel_low;
    } cct_ctrl_t;
    typedef struct packed {
        logic overflow_flag_high;
        logic match_flag_high;
        logic overflow_irq_en_high;
        logic clear_on_match_high;
        logic overflow_flag_low;
        logic match_flag_low;
        logic overflow_irq_en_low;
        logic clear_on_match_low;
    } cct_stat_t;
    typedef struct packed {
        logic irq_request_high;
        logic irq_request_low;
        logic irq_enable_high;
        logic irq_enable_low;
        logic event_edge_rise;
    } cct_aux_t;
endpackage

//--- cct_prescaler.sv
// Free-running divider giving one-cycle ticks at clk/32, /16, /4 and /2
`timescale 1ns/10ps
`default_nettype none
`include "cct_defs.svh"
module cct_prescaler
    import cct_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    output logic      [3:0] tick_o
);
    logic [`CCT_DIV32_BITS-1:0] div_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    // Index 0..3 selects /32, /16, /4, /2
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_o <= 4'h0;
        end else begin
            tick_o[0] <= &div_r[`CCT_DIV32_BITS-1:0];
            tick_o[1] <= &div_r[`CCT_DIV16_BITS-1:0];
            tick_o[2] <= &div_r[`CCT_DIV4_BITS-1:0];
            tick_o[3] <= &div_r[`CCT_DIV2_BITS-1:0];
        end
    end
endmodule // cct_prescaler
`default_nettype wire

//--- cct_timer.sv
// Cascadable 16-bit / dual 8-bit compare timer with Wishbone register access
// Summary of operation
// RL1: High select top bit 0 cascades halves; high byte advances on low overflow.
// RL2: High select top bit 1 runs halves independently on their own clock selects.
// RL3: Each half picks clk/32,/16,/4,/2; low half may count event pin edges.
// RL4: Reset clears both counter bytes.
// RL5: Reset sets both compare bytes to all ones.
// RL6: Wide counter wrap from all ones to zero sets high overflow flag.
// RL7: Overflow sets request bit only if enabled; CPU request needs its enable too.
// RL8: Split mode: each half wrapping sets its own overflow flag.
// RL9: Wide match sets high match flag and high request; CPU request if enabled.
// RL10: Split mode: each half match sets own match flag and request.
// RL11: Wide mode clears whole counter on match when high clear bit set.
// RL12: Split mode clears each half on own match when its clear bit set.
// RL13: Wide match inverts high toggle output; software may force its level.
// RL14: Split match inverts that half's toggle output; each level settable.
// RL15: Wide mode routes counter and compare access through a temporary byte.
// RL16: Control: bit7 high level, 6-4 high select, bit3 low level, 2-0 low select.
// RL17: Upper register is most significant byte; both bytes readable and writable.
// RL18: High select 0xx cascades; 100..111 select clk/32,/16,/4,/2.
// RL19: Low select 0xx counts event edges; 100..111 select the same prescaled clocks.
// RL20: Flags clear by reading 1 then writing 0; written ones are ignored.
// RL21: Writing an output level drives that toggle pin right after the write.
// RL22: Upper byte first: read latches low byte; low write updates both bytes.
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "cct_defs.svh"
module cct_timer
    import cct_pkg::*;
#(
    parameter int ADR_W = 18
)(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic             event_input_pin_i,
    output logic                  toggle_out_high_pin_o,
    output logic                  toggle_out_low_pin_o,
    output logic                  cpu_irq_high_o,
    output logic                  cpu_irq_low_o
);
    cct_ctrl_t  ctrl_r;
    cct_stat_t  stat_r;
    cct_aux_t   aux_r;
    logic [7:0] cnt_h_r, cnt_l_r, cmp_h_r, cmp_l_r, temp_r;
    logic [3:0] seen_r;
    logic [1:0] req_seen_r;
    logic       ev_prev_r;
    logic [3:0] tick;
    logic [7:0] wdat, rdata;
    logic       req, rd_take, wr_en, wr_byte;
    logic       mode16, ev_edge, tick_l, tick_h8;
    logic [15:0] cnt16, cmp16;
    logic       m16, clr16, ov16, m_h8, m_l8, ov_h8, ov_l8;
    logic       ovf_h_ev, ovf_l_ev, cmf_h_ev, cmf_l_ev;
    logic       wr_ctrl, wr_stat, wr_aux, wr_cnt_h, wr_cnt_l, wr_cmp_h, wr_cmp_l;

    function automatic logic reg_is(input logic [ADR_W-1:0] adr, input logic [15:0] idx);
        return adr[ADR_W-1:2] == idx[ADR_W-3:0];
    endfunction

    // Hardware set wins over a software clear in the same cycle
    function automatic logic flag_nxt(input logic cur, input logic set_ev, input logic wr,
                                      input logic seen, input logic wbit);
        return set_ev | (cur & ~(wr & seen & ~wbit));
    endfunction

    cct_prescaler u_presc (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .tick_o (tick)
    );

    // Bus strobes: read effects at request take, write effects on the ack edge
    assign req      = wb_cyc_i & wb_stb_i;
    assign rd_take  = req & ~wb_we_i & ~wb_ack_o;
    assign wr_en    = req & wb_we_i & wb_ack_o;
    assign wr_byte  = wr_en & wb_sel_i[0];
    assign wdat     = wb_dat_i[7:0];
    assign wr_ctrl  = wr_byte & reg_is(wb_adr_i, `CCT_IDX_CTRL);
    assign wr_stat  = wr_byte & reg_is(wb_adr_i, `CCT_IDX_STAT);
    assign wr_aux   = wr_byte & reg_is(wb_adr_i, `CCT_IDX_AUX);
    assign wr_cnt_h = wr_byte & reg_is(wb_adr_i, `CCT_IDX_CNT_H);
    assign wr_cnt_l = wr_byte & reg_is(wb_adr_i, `CCT_IDX_CNT_L);
    assign wr_cmp_h = wr_byte & reg_is(wb_adr_i, `CCT_IDX_CMP_H);
    assign wr_cmp_l = wr_byte & reg_is(wb_adr_i, `CCT_IDX_CMP_L);

    // Clock source selection
    assign mode16  = ~ctrl_r.clk_sel_high[2];                                     // RL1 RL2
    assign ev_edge = aux_r.event_edge_rise ? (event_input_pin_i & ~ev_prev_r)
                                           : (~event_input_pin_i & ev_prev_r);
    assign tick_l  = ctrl_r.clk_sel_low[2] ? tick[ctrl_r.clk_sel_low[1:0]] : ev_edge;   // RL3 RL19
    assign tick_h8 = ~mode16 & tick[ctrl_r.clk_sel_high[1:0]];                   // RL3 RL18

    // Match and overflow events
    assign cnt16 = {cnt_h_r, cnt_l_r};                                           // RL17
    assign cmp16 = {cmp_h_r, cmp_l_r};
    assign m16   = mode16 & tick_l & (cnt16 == cmp16);                           // RL9
    assign clr16 = m16 & stat_r.clear_on_match_high;                             // RL11
    assign ov16  = mode16 & tick_l & (cnt16 == `CCT_WIDE_MAX) & ~clr16;          // RL6
    assign m_h8  = tick_h8 & (cnt_h_r == cmp_h_r);                               // RL10
    assign m_l8  = ~mode16 & tick_l & (cnt_l_r == cmp_l_r);                      // RL10
    assign ov_h8 = tick_h8 & (cnt_h_r == `CCT_BYTE_MAX) & ~(m_h8 & stat_r.clear_on_match_high);   // RL8
    assign ov_l8 = ~mode16 & tick_l & (cnt_l_r == `CCT_BYTE_MAX)
                 & ~(m_l8 & stat_r.clear_on_match_low);                          // RL8
    assign ovf_h_ev = ov16 | ov_h8;
    assign ovf_l_ev = ov_l8;
    assign cmf_h_ev = m16 | m_h8;
    assign cmf_l_ev = m_l8;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ev_prev_r <= 1'b0;
        end else begin
            ev_prev_r <= event_input_pin_i;
        end
    end

    // Control register, write only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= `CCT_CTRL_RST;                                             // RL16
        end else if (wr_ctrl) begin
            ctrl_r <= cct_ctrl_t'(wdat);                                         // RL16
        end
    end

    // Counter bytes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_h_r <= `CCT_CNT_RST;                                             // RL4
            cnt_l_r <= `CCT_CNT_RST;                                             // RL4
        end else if (mode16) begin
            if (wr_cnt_l) begin
                {cnt_h_r, cnt_l_r} <= {temp_r, wdat};                            // RL15 RL22
            end else if (tick_l) begin
                {cnt_h_r, cnt_l_r} <= clr16 ? `CCT_WIDE_ZERO : cnt16 + 16'h0001;  // RL1 RL11
            end
        end else begin
            if (wr_cnt_h) begin
                cnt_h_r <= wdat;                                                 // RL17
            end else if (tick_h8) begin
                cnt_h_r <= (m_h8 & stat_r.clear_on_match_high) ? `CCT_CNT_RST : cnt_h_r + 8'h01;   // RL2 RL12
            end
            if (wr_cnt_l) begin
                cnt_l_r <= wdat;                                                 // RL17
            end else if (tick_l) begin
                cnt_l_r <= (m_l8 & stat_r.clear_on_match_low) ? `CCT_CNT_RST : cnt_l_r + 8'h01;    // RL2 RL12
            end
        end
    end

    // Compare bytes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp_h_r <= `CCT_CMP_RST;                                             // RL5
            cmp_l_r <= `CCT_CMP_RST;                                             // RL5
        end else if (mode16) begin
            if (wr_cmp_l) begin
                {cmp_h_r, cmp_l_r} <= {temp_r, wdat};                            // RL15 RL22
            end
        end else begin
            if (wr_cmp_h) begin
                cmp_h_r <= wdat;
            end
            if (wr_cmp_l) begin
                cmp_l_r <= wdat;
            end
        end
    end

    // Temporary byte for coherent wide access
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            temp_r <= 8'h00;
        end else if (mode16) begin
            if (wr_cnt_h | wr_cmp_h) begin
                temp_r <= wdat;                                                  // RL22
            end else if (rd_take & reg_is(wb_adr_i, `CCT_IDX_CNT_H)) begin
                temp_r <= cnt_l_r;                                               // RL15 RL22
            end else if (rd_take & reg_is(wb_adr_i, `CCT_IDX_CMP_H)) begin
                temp_r <= cmp_l_r;                                               // RL15 RL22
            end
        end
    end

    // Flags seen as one by a read, armed for a zero-write clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seen_r     <= 4'h0;
            req_seen_r <= 2'h0;
        end else begin
            if (rd_take & reg_is(wb_adr_i, `CCT_IDX_STAT)) begin
                seen_r <= {stat_r.overflow_flag_high, stat_r.match_flag_high,
                           stat_r.overflow_flag_low, stat_r.match_flag_low};
            end else if (wr_stat) begin
                seen_r <= 4'h0;
            end
            if (rd_take & reg_is(wb_adr_i, `CCT_IDX_AUX)) begin
                req_seen_r <= {aux_r.irq_request_high, aux_r.irq_request_low};
            end else if (wr_aux) begin
                req_seen_r <= 2'h0;
            end
        end
    end

    // Control/status: flags set by hardware, enables written directly
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_r <= `CCT_STAT_RST;
        end else begin
            stat_r.overflow_flag_high <= flag_nxt(stat_r.overflow_flag_high, ovf_h_ev, wr_stat,
                                                  seen_r[3], wdat[`CCT_BIT_OVF_H]);      // RL6 RL20
            stat_r.match_flag_high    <= flag_nxt(stat_r.match_flag_high, cmf_h_ev, wr_stat,
                                                  seen_r[2], wdat[`CCT_BIT_CMF_H]);      // RL9 RL20
            stat_r.overflow_flag_low  <= flag_nxt(stat_r.overflow_flag_low, ovf_l_ev, wr_stat,
                                                  seen_r[1], wdat[`CCT_BIT_OVF_L]);      // RL8 RL20
            stat_r.match_flag_low     <= flag_nxt(stat_r.match_flag_low, cmf_l_ev, wr_stat,
                                                  seen_r[0], wdat[`CCT_BIT_CMF_L]);      // RL10 RL20
            if (wr_stat) begin
                stat_r.overflow_irq_en_high <= wdat[`CCT_BIT_OVIE_H];
                stat_r.clear_on_match_high  <= wdat[`CCT_BIT_CCLR_H];
                stat_r.overflow_irq_en_low  <= wdat[`CCT_BIT_OVIE_L];
                stat_r.clear_on_match_low   <= wdat[`CCT_BIT_CCLR_L];
            end
        end
    end

    // Interrupt request and enable bits, edge polarity
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aux_r <= `CCT_AUX_RST;
        end else begin
            aux_r.irq_request_high <= flag_nxt(aux_r.irq_request_high,
                                               (ovf_h_ev & stat_r.overflow_irq_en_high) | cmf_h_ev,
                                               wr_aux, req_seen_r[1], wdat[`CCT_BIT_REQ_H]);   // RL7 RL9
            aux_r.irq_request_low  <= flag_nxt(aux_r.irq_request_low,
                                               (ovf_l_ev & stat_r.overflow_irq_en_low) | cmf_l_ev,
                                               wr_aux, req_seen_r[0], wdat[`CCT_BIT_REQ_L]);   // RL7 RL10
            if (wr_aux) begin
                aux_r.irq_enable_high <= wdat[`CCT_BIT_IEN_H];
                aux_r.irq_enable_low  <= wdat[`CCT_BIT_IEN_L];
                aux_r.event_edge_rise <= wdat[`CCT_BIT_EDGE];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_irq_high_o <= 1'b0;
            cpu_irq_low_o  <= 1'b0;
        end else begin
            cpu_irq_high_o <= aux_r.irq_request_high & aux_r.irq_enable_high;    // RL7
            cpu_irq_low_o  <= aux_r.irq_request_low & aux_r.irq_enable_low;      // RL7
        end
    end

    // Toggle pins: a control write forces the level, else a match inverts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            toggle_out_high_pin_o <= 1'b0;
            toggle_out_low_pin_o  <= 1'b0;
        end else if (wr_ctrl) begin
            toggle_out_high_pin_o <= wdat[`CCT_BIT_OL_H];                        // RL13 RL21
            toggle_out_low_pin_o  <= wdat[`CCT_BIT_OL_L];                        // RL14 RL21
        end else begin
            if (cmf_h_ev) begin
                toggle_out_high_pin_o <= ~toggle_out_high_pin_o;                 // RL13 RL14
            end
            if (cmf_l_ev) begin
                toggle_out_low_pin_o <= ~toggle_out_low_pin_o;                   // RL14
            end
        end
    end

    // Read mux; low bytes come from the temporary byte in wide mode
    always_comb begin
        rdata = 8'h00;
        if (reg_is(wb_adr_i, `CCT_IDX_STAT)) begin
            rdata = stat_r;
        end else if (reg_is(wb_adr_i, `CCT_IDX_AUX)) begin
            rdata = {3'h0, aux_r};
        end else if (reg_is(wb_adr_i, `CCT_IDX_CNT_H)) begin
            rdata = cnt_h_r;
        end else if (reg_is(wb_adr_i, `CCT_IDX_CMP_H)) begin
            rdata = cmp_h_r;
        end else if (reg_is(wb_adr_i, `CCT_IDX_CNT_L)) begin
            rdata = mode16 ? temp_r : cnt_l_r;                                   // RL15
        end else if (reg_is(wb_adr_i, `CCT_IDX_CMP_L)) begin
            rdata = mode16 ? temp_r : cmp_l_r;                                   // RL15
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
            if (rd_take) begin
                wb_dat_o <= {24'h00_0000, rdata};
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_reset_vals;
        $fell(rst_i) |-> cnt16 == `CCT_WIDE_ZERO && cmp16 == `CCT_WIDE_MAX;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset values"); // RL4

    property p_cascade;
        mode16 && tick_l && cnt_l_r == `CCT_BYTE_MAX && !clr16 && !wr_en
            |=> cnt_h_r == $past(cnt_h_r) + 8'h01 && cnt_l_r == 8'h00;
    endproperty
    a_cascade: assert property (p_cascade) else $error("high byte missed carry"); // RL1

    property p_split_hold;
        !mode16 && !tick_h8 && !wr_en && !$past(mode16) |=> $stable(cnt_h_r);
    endproperty
    a_split_hold: assert property (p_split_hold) else $error("high half moved untimed"); // RL2

    property p_wide_ovf;
        ov16 && !wr_en |=> stat_r.overflow_flag_high && cnt16 == `CCT_WIDE_ZERO;
    endproperty
    a_wide_ovf: assert property (p_wide_ovf) else $error("wide wrap not flagged"); // RL6

    property p_low_ovf;
        ov_l8 |=> stat_r.overflow_flag_low ##2 stat_r.overflow_flag_low || $past(wr_stat, 2) || $past(wr_stat);
    endproperty
    a_low_ovf: assert property (p_low_ovf) else $error("low wrap not flagged"); // RL8

    property p_ovf_req;
        ovf_h_ev && stat_r.overflow_irq_en_high && aux_r.irq_enable_high && !wr_en
            |=> aux_r.irq_request_high ##1 cpu_irq_high_o;
    endproperty
    a_ovf_req: assert property (p_ovf_req) else $error("overflow request lost"); // RL7

    property p_match16;
        m16 |=> stat_r.match_flag_high && aux_r.irq_request_high;
    endproperty
    a_match16: assert property (p_match16) else $error("wide match not flagged"); // RL9

    property p_clear16;
        clr16 && !wr_en |=> cnt16 == `CCT_WIDE_ZERO;
    endproperty
    a_clear16: assert property (p_clear16) else $error("counter not cleared on match"); // RL11

    property p_toggle;
        cmf_h_ev && !wr_ctrl |=> toggle_out_high_pin_o != $past(toggle_out_high_pin_o);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle output did not invert"); // RL13

    property p_level_write;
        wr_ctrl |=> toggle_out_high_pin_o == $past(wdat[`CCT_BIT_OL_H])
                 && toggle_out_low_pin_o == $past(wdat[`CCT_BIT_OL_L]);
    endproperty
    a_level_write: assert property (p_level_write) else $error("level write not applied"); // RL21

    property p_one_ignored;
        wr_stat && wdat[`CCT_BIT_CMF_L] && !stat_r.match_flag_low && !cmf_l_ev
            |=> !stat_r.match_flag_low;
    endproperty
    a_one_ignored: assert property (p_one_ignored) else $error("flag set by software"); // RL20

    c_match16:  cover property (m16 && stat_r.clear_on_match_high);
    c_split_ov: cover property (ov_h8 ##[1:50] ov_l8);
    c_temp_rd:  cover property (mode16 && rd_take && reg_is(wb_adr_i, `CCT_IDX_CNT_H));
endmodule // cct_timer
`default_nettype wire

//--- cct_timer_bench.sv
// Self-checking bench for the compare timer: register table, split and wide counting
`timescale 1ns/10ps
`default_nettype none
`include "cct_defs.svh"
module cct_timer_bench;
    typedef struct packed {
        logic        we;
        logic [15:0] idx;
        logic [7:0]  wd;
        logic [7:0]  ex;
        logic [1:0]  pins;
    } cct_row_t;
    localparam cct_row_t ROWS [15] = '{
        '{1'b0, `CCT_IDX_STAT, 8'h00, 8'h00, 2'h0}, '{1'b0, `CCT_IDX_CNT_H, 8'h00, 8'h00, 2'h0},
        '{1'b0, `CCT_IDX_CNT_L, 8'h00, 8'h00, 2'h0}, '{1'b0, `CCT_IDX_CMP_H, 8'h00, 8'hFF, 2'h0},
        '{1'b0, `CCT_IDX_CMP_L, 8'h00, 8'hFF, 2'h0}, '{1'b0, `CCT_IDX_CTRL, 8'h00, 8'h00, 2'h0},
        '{1'b0, 16'hFFC0, 8'h00, 8'h00, 2'h0}, '{1'b1, `CCT_IDX_CMP_H, 8'h05, 8'h00, 2'h0},
        '{1'b1, `CCT_IDX_CMP_L, 8'h05, 8'h00, 2'h0}, '{1'b0, `CCT_IDX_CMP_H, 8'h00, 8'h05, 2'h0},
        '{1'b0, `CCT_IDX_CMP_L, 8'h00, 8'h05, 2'h0}, '{1'b1, `CCT_IDX_STAT, 8'hFF, 8'h00, 2'h0},
        '{1'b0, `CCT_IDX_STAT, 8'h00, 8'h33, 2'h0}, '{1'b1, `CCT_IDX_CTRL, 8'h88, 8'h00, 2'h3},
        '{1'b1, `CCT_IDX_CTRL, 8'h00, 8'h00, 2'h0}
    };
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [17:0] adr = 18'h00000;
    logic [31:0] dat = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, pin_h, pin_l, irq_h, irq_l, ev;
    logic [15:0] eh, el, e0h, e0l;
    logic [7:0]  q;
    int          fail_count = 0, total_checks = 0, cycles = 0;

    always #4 clk_i = ~clk_i;

    cct_timer #(.ADR_W(18)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .event_input_pin_i(ev), .toggle_out_high_pin_o(pin_h),
        .toggle_out_low_pin_o(pin_l), .cpu_irq_high_o(irq_h), .cpu_irq_low_o(irq_l));
    cct_far_side far (.clk_i(clk_i), .rst_i(rst_i), .tog_h_i(pin_h), .tog_l_i(pin_l), .event_o(ev),
        .edges_h_o(eh), .edges_l_o(el));

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask

    task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dat <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1);
        chk("ack latency", 16'h0002, n[15:0]);
        q = wb_dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] idx, input logic [7:0] exp, input string what);
        wb(1'b0, idx, 8'h00);
        chk(what, {8'h00, exp}, {8'h00, q});
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            fail_count++;
            finish_test();
        end
    end

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 15; i++) begin
            wb(ROWS[i].we, ROWS[i].idx, ROWS[i].wd);
            @(negedge clk_i);
            if (!ROWS[i].we) chk("register", {8'h00, ROWS[i].ex}, {8'h00, q});
            chk("pins", {14'h0000, ROWS[i].pins}, {14'h0000, pin_h, pin_l});
        end
        $display("Test register table done");
        // Split halves at clk/2 with clear on match at 5
        wb(1'b1, `CCT_IDX_STAT, 8'h11);
        e0h = eh;
        e0l = el;
        wb(1'b1, `CCT_IDX_CTRL, 8'h77);
        wb(1'b1, `CCT_IDX_CNT_L, 8'hFA);
        repeat (200) @(posedge clk_i);
        wb(1'b1, `CCT_IDX_CTRL, 8'h00);
        rd(`CCT_IDX_STAT, 8'h5D, "split flags");
        wb(1'b0, `CCT_IDX_CNT_H, 8'h00);
        chk("high half bound", 16'h0001, {15'h0000, q <= 8'h05});
        chk("high toggles", 16'h0001, {15'h0000, (eh - e0h) >= 16'd10});
        chk("low toggles", 16'h0001, {15'h0000, (el - e0l) >= 16'd10});
        wb(1'b1, `CCT_IDX_STAT, 8'h11);
        rd(`CCT_IDX_STAT, 8'h11, "flags cleared");
        $display("Test split mode done");
        // Wide mode counting event edges across the wrap
        wb(1'b1, `CCT_IDX_STAT, 8'h20);
        rd(`CCT_IDX_AUX, 8'h18, "split requests");
        wb(1'b1, `CCT_IDX_AUX, 8'h04);
        wb(1'b1, `CCT_IDX_CNT_H, 8'hFF);
        wb(1'b1, `CCT_IDX_CNT_L, 8'hFD);
        wb(1'b1, `CCT_IDX_CMP_H, 8'h00);
        wb(1'b1, `CCT_IDX_CMP_L, 8'h02);
        e0h = eh;
        far.pulse(3, 2);
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        chk("irq high", 16'h0001, {15'h0000, irq_h});
        chk("irq low", 16'h0000, {15'h0000, irq_l});
        rd(`CCT_IDX_STAT, 8'hA0, "wide overflow");
        rd(`CCT_IDX_CNT_H, 8'h00, "wrap high");
        rd(`CCT_IDX_CNT_L, 8'h00, "wrap low");
        far.pulse(3, 5);
        rd(`CCT_IDX_STAT, 8'hE0, "wide match");
        rd(`CCT_IDX_CNT_H, 8'h00, "no clear high");
        rd(`CCT_IDX_CNT_L, 8'h03, "no clear low");
        chk("wide toggle", 16'h0001, eh - e0h);
        wb(1'b1, `CCT_IDX_STAT, 8'h30);
        wb(1'b1, `CCT_IDX_CNT_H, 8'h00);
        wb(1'b1, `CCT_IDX_CNT_L, 8'h00);
        far.pulse(4, 2);
        rd(`CCT_IDX_STAT, 8'h70, "clear on match");
        rd(`CCT_IDX_CNT_H, 8'h00, "cleared high");
        rd(`CCT_IDX_CNT_L, 8'h01, "cleared low");
        $display("Test wide mode done");
        // Reset again in mid-run
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`CCT_IDX_STAT, 8'h00, "reset status");
        rd(`CCT_IDX_CMP_H, 8'hFF, "reset compare");
        rd(`CCT_IDX_CNT_H, 8'h00, "reset counter high");
        rd(`CCT_IDX_CNT_L, 8'h00, "reset counter low");
        chk("reset pins", 16'h0000, {14'h0000, pin_h, pin_l});
        chk("reset irq", 16'h0000, {14'h0000, irq_h, irq_l});
        $display("Test reset done");
        finish_test();
    end
endmodule // cct_timer_bench
`default_nettype wire
